/* srst_asserts.sv */
// checker on the self-test top ports
// assumes one clock domain; bound into every srst_top instance
`timescale 1ns/1ps
module srst_asserts
    import srst_pkg::*;
#(
    parameter int unsigned BLINK_HALF = 4,
    parameter int unsigned WORDS      = 16
) (
    // clock, reset, button
    input wire logic                        clk_i,
    input wire logic                        nrst_i,
    input wire logic                        start_button_n_i,
    // memory port
    input wire logic                        mem_wr_o,
    input wire logic                        mem_rd_o,
    input wire logic [srst_pkg::ADDR_W-1:0] mem_addr_o,
    input wire logic [srst_pkg::DATA_W-1:0] mem_wdata_o,
    input wire logic                        mem_wait_i,
    input wire logic                        mem_rvalid_i,
    input wire logic [srst_pkg::DATA_W-1:0] mem_rdata_i,
    // status
    input wire logic [2:0]                  red_status_leds_o,
    input wire logic                        test_done_o,
    input wire logic                        test_pass_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    localparam logic [ADDR_W-1:0] LAST = ADDR_W'(WORDS - 1);
    logic [31:0] stay_r;
    logic        warm_r;

    // own copy of the sequence step, kept apart from the design's
    function automatic logic [DATA_W-1:0] nstep(input logic [DATA_W-1:0] v);
        nstep = v[0] ? ((v >> 1) ^ LFSR_POLY) : (v >> 1);
    endfunction : nstep

    // cycles the clock-alive led has held its level; restarts after reset and
    // around a button hold, where the led is forced on
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stay_r <= '0;
            warm_r <= 1'b0;
        end else begin
            warm_r <= 1'b1;
            if (!warm_r || !start_button_n_i || $rose(start_button_n_i)
                || $changed(red_status_leds_o[2])) begin
                stay_r <= '0;
            end else begin
                stay_r <= stay_r + 1'b1;
            end
        end
    end

    sequence wr_taken;
        mem_wr_o && !mem_wait_i && start_button_n_i;
    endsequence
    sequence released;
        !start_button_n_i ##1 start_button_n_i;
    endsequence

    // ====================================================================
    // assertions
    launch_a: assert property (released |=>
        mem_wr_o && mem_addr_o == '0 && mem_wdata_o == LFSR_SEED)
        else $error("run start wrong");
    held_leds_a: assert property (!start_button_n_i |=>
        red_status_leds_o == LEDS_ALL && !mem_wr_o && !mem_rd_o && !test_done_o)
        else $error("held button state wrong");
    addr_step_a: assert property (wr_taken |=>
        mem_wr_o ? mem_addr_o == ADDR_W'($past(mem_addr_o) + 1'b1)
                 : mem_rd_o && mem_addr_o == '0 && $past(mem_addr_o) == LAST)
        else $error("address did not step");
    data_step_a: assert property (wr_taken |=>
        !mem_wr_o || mem_wdata_o == nstep($past(mem_wdata_o)))
        else $error("write word off sequence");
    pass_order_a: assert property (mem_wr_o |-> !mem_rd_o && !test_done_o)
        else $error("read during write pass");
    req_hold_a: assert property (
        (mem_wr_o || mem_rd_o) && mem_wait_i && start_button_n_i |=>
        $stable({mem_wr_o, mem_rd_o, mem_addr_o}) && (!mem_wr_o || $stable(mem_wdata_o)))
        else $error("stalled request changed");
    run_blink_a: assert property (mem_wr_o || mem_rd_o |->
        red_status_leds_o[0] && red_status_leds_o[1] == red_status_leds_o[2])
        else $error("run leds wrong");
    alive_blink_a: assert property (stay_r <= BLINK_HALF)
        else $error("clock-alive led stuck");
    done_leds_a: assert property (test_done_o |->
        !mem_wr_o && !mem_rd_o && red_status_leds_o[1] == test_pass_o)
        else $error("done leds wrong");
endmodule : srst_asserts

bind srst_top srst_asserts #(.BLINK_HALF(BLINK_HALF), .WORDS(WORDS)) i_srst_asserts (
    .clk_i(clk_i), .nrst_i(nrst_i), .start_button_n_i(start_button_n_i),
    .mem_wr_o(mem_wr_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_wait_i(mem_wait_i), .mem_rvalid_i(mem_rvalid_i),
    .mem_rdata_i(mem_rdata_i), .red_status_leds_o(red_status_leds_o),
    .test_done_o(test_done_o), .test_pass_o(test_pass_o)
);

/* srst_gen_if.sv */
// carrier between the self-test sequencer and its sequence generator
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface srst_gen_if;
    import srst_pkg::*;

    logic              restart;    // back to seed
    logic              advance;    // step once
    logic [DATA_W-1:0] value;      // current word
    logic [DATA_W-1:0] value_next; // word after the next edge if advanced

    modport ctrl (output restart, output advance, input value, input value_next);
    modport gen  (input restart, input advance, output value, output value_next);
endinterface : srst_gen_if

/* srst_mem_model.sv */
// behavioural memory controller in front of the self-test
// assumes it runs from the same reference clock as the block under test
`timescale 1ns/1ps
module srst_mem_model
    import srst_pkg::*;
(
    // clock and reset
    input wire logic                        clk_i,
    input wire logic                        nrst_i,
    // stall every other cycle when high
    input wire logic                        slow_i,
    // corrupt the word read back from address three when high
    input wire logic                        flip_i,
    // word port
    input wire logic                        wr_i,
    input wire logic                        rd_i,
    input wire logic [srst_pkg::ADDR_W-1:0] addr_i,
    input wire logic [srst_pkg::DATA_W-1:0] wdata_i,
    output logic                            wait_o,
    output logic                            rvalid_o,
    output logic [srst_pkg::DATA_W-1:0]     rdata_o
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];

    // model runs off the reference clock; memory clock is internal to it
    // stores written words, answers reads next cycle, idle data keeps flipping
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_o   <= 1'b0;
            rvalid_o <= 1'b0;
            rdata_o  <= '0;
        end else begin
            wait_o   <= slow_i && !wait_o;
            rvalid_o <= rd_i && !wait_o;
            if (wr_i && !wait_o) mem[addr_i] = wdata_i;
            if (rd_i && !wait_o && mem.exists(addr_i))
                rdata_o <= mem[addr_i] ^ {15'h0000, flip_i && addr_i == ADDR_W'(3)};
            else rdata_o <= ~rdata_o;
        end
    end
endmodule : srst_mem_model

/* srst_patgen.sv */
// test sequence generator: lfsr stepping on request
// assumes the sequencer restarts it at the start of every pass
`timescale 1ns/1ps
module srst_patgen (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // sequencer side
    srst_gen_if.gen   gen
);
    import srst_pkg::*;

    logic [DATA_W-1:0] value_r;

    // seed on restart, step on advance
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            value_r <= LFSR_SEED;
        end else if (gen.restart) begin
            value_r <= LFSR_SEED;           // [R13]
        end else if (gen.advance) begin
            value_r <= lfsr_step(value_r);
        end
    end

    assign gen.value      = value_r;
    assign gen.value_next = lfsr_step(value_r);

endmodule : srst_patgen

/* srst_pkg.sv */
// constants and helpers shared by the sdram write/read self-test
// assumes a 50 MHz system clock and a 16-bit wide, 64 MB memory behind a controller
package srst_pkg;

    // ====================================================================
    // memory geometry
    localparam int unsigned MEM_BYTES   = 64 * 1024 * 1024;  // bank under test
    localparam int unsigned WORD_BYTES  = 2;                 // 16-bit data bus
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned MEM_WORDS   = MEM_BYTES / WORD_BYTES;  // words in the bank
    localparam int unsigned ADDR_W      = $clog2(MEM_WORDS);

    // ====================================================================
    // clocks
    localparam int unsigned REF_CLK_HZ  = 50_000_000;   // controller reference
    localparam int unsigned MEM_CLK_HZ  = 2 * REF_CLK_HZ; // memory clock made by controller

    // ====================================================================
    // led blink timing
    localparam int unsigned BLINK_HALF_MS  = 250;
    localparam int unsigned BLINK_HALF_CYC = (REF_CLK_HZ / 1000) * BLINK_HALF_MS;

    // ====================================================================
    // test sequence generator
    localparam logic [DATA_W-1:0] LFSR_SEED = 16'hACE1;
    localparam logic [DATA_W-1:0] LFSR_POLY = 16'hB400;

    // ====================================================================
    // led positions
    localparam int unsigned LED_BUSY  = 0;
    localparam int unsigned LED_PASS  = 1;
    localparam int unsigned LED_ALIVE = 2;
    localparam logic [2:0]  LEDS_ALL  = 3'h7;

    // ====================================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HELD,
        ST_WRITE,
        ST_READ,
        ST_DONE
    } srst_state_t;

    // one galois lfsr step
    function automatic logic [DATA_W-1:0] lfsr_step(input logic [DATA_W-1:0] v);
        lfsr_step = v[0] ? ((v >> 1) ^ LFSR_POLY) : (v >> 1);
    endfunction : lfsr_step

endpackage : srst_pkg

/* srst_top.sv */
// sdram write/read self-test: start button, write pass, read/compare pass, leds
// assumes a memory controller with a word request port (wait, read-valid) clocked
// from clk_i as its reference; button level low while pressed, synchronous
`timescale 1ns/1ps

// Functional notes
// [R1] button press launches a memory test run
// [R2] every word of 64 MB is addressed
// [R3] whole write pass precedes any read compare
// [R4] read pass regenerates sequence and compares words
// [R5] controller is referenced to the 50 MHz clock
// [R6] controller makes 100 MHz memory clock
// [R7] button held lights status leds two to zero
// [R8] clock-alive led blinks from reference clock
// [R9] clean run ends with pass led steady
// [R10] any mismatch leaves pass led off
// [R11] new press restarts run, clears old result
// [R12] pass led blinks in run, result latched
// [R13] generator reseeded at each pass start
module srst_top #(
    parameter int unsigned BLINK_HALF = srst_pkg::BLINK_HALF_CYC,
    parameter int unsigned WORDS      = srst_pkg::MEM_WORDS
) (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        nrst_i,
    // start button, low while pressed
    input  wire logic                        start_button_n_i,
    // memory controller word port
    output logic                             mem_wr_o,
    output logic                             mem_rd_o,
    output logic [srst_pkg::ADDR_W-1:0]      mem_addr_o,
    output logic [srst_pkg::DATA_W-1:0]      mem_wdata_o,
    input  wire logic                        mem_wait_i,
    input  wire logic                        mem_rvalid_i,
    input  wire logic [srst_pkg::DATA_W-1:0] mem_rdata_i,
    // status leds
    output logic [2:0]                       red_status_leds_o,
    output logic                             test_done_o,
    output logic                             test_pass_o
);
    import srst_pkg::*;

    // ====================================================================
    // declarations
    localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(WORDS - 1);  // [R2]
    localparam int unsigned       BLINK_W   = $clog2(BLINK_HALF + 1);

    srst_state_t        state_r;
    srst_state_t        state_nxt;
    logic [ADDR_W-1:0]  rcv_cnt_r;
    logic               mismatch_r;
    logic               wr_accept;
    logic               rd_accept;
    logic               rd_match;
    logic               last_rcv;
    logic               pressed;
    logic [BLINK_W-1:0] blink_cnt_r;
    logic               blink_tick;
    logic               blink_r;

    srst_gen_if gen_if ();

    srst_patgen u_patgen (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .gen    (gen_if.gen)
    );

    // ====================================================================
    // handshake decode
    // a request is taken in a cycle it is high and the controller does not wait;
    // the controller's own 100 MHz memory clock is derived inside it from clk_i
    assign pressed   = !start_button_n_i;
    assign wr_accept = mem_wr_o && !mem_wait_i;   // [R5] [R6]
    assign rd_accept = mem_rd_o && !mem_wait_i;
    assign rd_match  = (mem_rdata_i == gen_if.value);
    assign last_rcv  = mem_rvalid_i && (rcv_cnt_r == ADDR_LAST);

    // ====================================================================
    // sequencer
    always_comb begin
        state_nxt = state_r;
        if (pressed) begin
            state_nxt = ST_HELD;                  // [R1] [R11]
        end else begin
            unique case (state_r)
                ST_IDLE:  state_nxt = ST_IDLE;
                ST_HELD:  state_nxt = ST_WRITE;   // release starts the run
                ST_WRITE: begin
                    if (wr_accept && mem_addr_o == ADDR_LAST) begin
                        state_nxt = ST_READ;      // [R3]
                    end
                end
                ST_READ: begin
                    if (state_r == ST_READ && last_rcv) begin
                        state_nxt = ST_DONE;
                    end
                end
                ST_DONE:  state_nxt = ST_DONE;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // generator control: reseed at each pass start, step per word
    always_comb begin
        gen_if.restart = (state_r == ST_HELD && !pressed)            // [R13]
                       || (state_r == ST_WRITE && state_nxt == ST_READ);
        gen_if.advance = (state_r == ST_WRITE && wr_accept)
                       || (state_r == ST_READ && mem_rvalid_i);       // [R4]
    end

    // ====================================================================
    // request issue: write pass then read pass over every address
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_wr_o    <= 1'b0;
            mem_rd_o    <= 1'b0;
            mem_addr_o  <= '0;
            mem_wdata_o <= '0;
        end else if (pressed) begin
            mem_wr_o   <= 1'b0;
            mem_rd_o   <= 1'b0;
            mem_addr_o <= '0;
        end else if (state_r == ST_HELD) begin
            mem_wr_o    <= 1'b1;
            mem_addr_o  <= '0;
            mem_wdata_o <= LFSR_SEED;             // [R13]
        end else if (wr_accept) begin
            if (mem_addr_o == ADDR_LAST) begin
                mem_wr_o   <= 1'b0;
                mem_rd_o   <= 1'b1;               // [R3]
                mem_addr_o <= '0;
            end else begin
                mem_addr_o  <= mem_addr_o + 1'b1; // [R2]
                mem_wdata_o <= gen_if.value_next;
            end
        end else if (rd_accept) begin
            if (mem_addr_o == ADDR_LAST) begin
                mem_rd_o <= 1'b0;
            end else begin
                mem_addr_o <= mem_addr_o + 1'b1;  // [R2]
            end
        end
    end

    // ====================================================================
    // read-back compare: counts answers, latches any mismatch until next press
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rcv_cnt_r  <= '0;
            mismatch_r <= 1'b0;
        end else if (pressed) begin
            rcv_cnt_r  <= '0;
            mismatch_r <= 1'b0;                   // [R11]
        end else if (state_r == ST_READ && mem_rvalid_i) begin
            rcv_cnt_r <= rcv_cnt_r + 1'b1;
            if (!rd_match) begin
                mismatch_r <= 1'b1;               // [R4] [R12]
            end
        end
    end

    // ====================================================================
    // blink divider: one-cycle tick every half period
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            blink_cnt_r <= '0;
        end else if (blink_tick) begin
            blink_cnt_r <= '0;
        end else begin
            blink_cnt_r <= blink_cnt_r + 1'b1;
        end
    end

    assign blink_tick = (blink_cnt_r == BLINK_W'(BLINK_HALF - 1));

    // blink phase
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            blink_r <= 1'b0;
        end else if (blink_tick) begin
            blink_r <= !blink_r;                  // [R8]
        end
    end

    // ====================================================================
    // leds and result outputs
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            red_status_leds_o <= '0;
            test_done_o       <= 1'b0;
            test_pass_o       <= 1'b0;
        end else if (pressed) begin
            red_status_leds_o <= LEDS_ALL;        // [R7]
            test_done_o       <= 1'b0;
            test_pass_o       <= 1'b0;
        end else begin
            red_status_leds_o[LED_ALIVE] <= blink_r;  // [R8]
            red_status_leds_o[LED_BUSY]  <= (state_nxt == ST_WRITE)
                                         || (state_nxt == ST_READ);
            unique case (state_nxt)
                ST_WRITE, ST_READ: begin
                    red_status_leds_o[LED_PASS] <= blink_r;  // [R12]
                end
                ST_DONE: begin
                    // steady on only for a clean run
                    red_status_leds_o[LED_PASS] <= !(mismatch_r
                        || (state_r == ST_READ && !rd_match));  // [R9] [R10]
                end
                default: begin
                    red_status_leds_o[LED_PASS] <= 1'b0;
                end
            endcase
            test_done_o <= (state_nxt == ST_DONE);
            test_pass_o <= (state_nxt == ST_DONE)
                        && !(mismatch_r || (state_r == ST_READ && !rd_match));
        end
    end

endmodule : srst_top

/* testbench.sv */
// self-checking bench for the sdram self-test top
// assumes the memory model file and the checker bind are compiled before it
`timescale 1ns/1ps
module testbench;
    import srst_pkg::*;
    localparam int unsigned BH = 4;
    localparam int unsigned W  = 16;  // words per run, keeps full runs short
    logic              clk_i  = 1'b0;
    logic              nrst_i = 1'b0;
    logic              btn_n  = 1'b1;
    logic              slow   = 1'b0;
    logic              flip   = 1'b0;
    logic              wr, rd, wt, rv, done, pass;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wd, rdt;
    logic [2:0]        leds;
    int                error_cnt = 0;
    int                n_checks  = 0;

    always #10 clk_i = ~clk_i;

    srst_top #(.BLINK_HALF(BH), .WORDS(W)) i_srst_top (
        .clk_i(clk_i), .nrst_i(nrst_i), .start_button_n_i(btn_n), .mem_wr_o(wr),
        .mem_rd_o(rd), .mem_addr_o(addr), .mem_wdata_o(wd), .mem_wait_i(wt),
        .mem_rvalid_i(rv), .mem_rdata_i(rdt), .red_status_leds_o(leds),
        .test_done_o(done), .test_pass_o(pass));
    srst_mem_model i_srst_mem_model (
        .clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow), .wr_i(wr), .rd_i(rd),
        .flip_i(flip), .addr_i(addr), .wdata_i(wd), .wait_o(wt), .rvalid_o(rv),
        .rdata_o(rdt));

    function automatic logic [DATA_W-1:0] nx(input logic [DATA_W-1:0] v);
        nx = v[0] ? ((v >> 1) ^ LFSR_POLY) : (v >> 1);
    endfunction : nx

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk

    task automatic give_verdict();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    // press and hold: leds all on, requests dropped
    task automatic t_press();
        @(posedge clk_i) btn_n <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk("held leds", 32'h7, leds);
        chk("held req", 32'h0, {wr, rd, done, pass});
    endtask : t_press

    // release, follow the writes and reads; stop > 0 leaves after that many writes
    task automatic t_run(input logic sl, input logic bad, input int stop);
        logic [ADDR_W-1:0] ea;
        logic [ADDR_W-1:0] ra;
        logic [DATA_W-1:0] ed;
        int                k;
        int                kr;
        int                cyc;
        ea = '0;
        ra = '0;
        ed = LFSR_SEED;
        k = 0;
        kr = 0;
        cyc = 0;
        @(posedge clk_i) begin
            btn_n <= 1'b1;
            slow  <= sl;
            flip  <= bad;
        end
        repeat (2) @(negedge clk_i);
        chk("launch", 32'h1, wr);
        while (cyc < 8 * W && (stop > 0 ? k < stop : done !== 1'b1)) begin
            if (wr && !wt) begin
                chk("addr", ea, addr);
                chk("wdata", ed, wd);
                chk("no read", 32'h0, {rd, done});
                chk("run leds", {leds[2], 1'b1}, {leds[1], leds[0]});
                ea = ea + 1'b1;
                ed = nx(ed);
                k++;
            end
            if (rd && !wt) begin
                chk("read addr", ra, addr);
                chk("writes first", W, k);
                chk("read leds", {leds[2], 1'b1}, {leds[1], leds[0]});
                ra = ra + 1'b1;
                kr++;
            end
            @(negedge clk_i);
            cyc++;
        end
        if (stop > 0) begin
            chk("writes", stop, k);
        end else begin
            chk("writes", W, k);
            chk("reads", W, kr);
            chk("result", {1'b1, !bad, !bad, 1'b0}, {done, pass, leds[1], leds[0]});
        end
    endtask : t_run

    // one full level of the clock-alive led lasts BH cycles
    task automatic t_blink();
        logic l;
        int   c;
        l = leds[2];
        c = 0;
        while (leds[2] === l && c < 50) begin
            @(negedge clk_i);
            c++;
        end
        l = leds[2];
        c = 0;
        while (leds[2] === l && c < 50) begin
            @(negedge clk_i);
            c++;
        end
        chk("alive half", BH, c);
    endtask : t_blink

    // ====================================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        chk("idle", 32'h0, {wr, rd, leds[1:0], done, pass});
        t_blink();
        t_press();
        t_run(1'b0, 1'b0, 0);
        t_press();
        t_run(1'b0, 1'b0, 5);
        t_press();
        t_run(1'b1, 1'b1, 0);
        t_press();
        t_run(1'b1, 1'b0, 0);
        t_blink();
        give_verdict();
    end

    // watchdog: the runs need well under a thousand cycles, allow ten thousand
    initial begin
        #200_000;
        error_cnt++;
        give_verdict();
    end
endmodule : testbench
